// ==== src/rpc_panel.sv ====
// Panel side RGB pixel input: window decode, power sequencing, serial config capture
// How it works
// R1: Host keeps pixel clock two frames after shutdown
// R2: Blank on second vsync fall after shutdown rise
// R3: Host resets only after two shutdown frames
// R4: Host waits two frames before display off
// R5: Serial writes are three-wire, 24 bits each
// R6: Each channel is 8-bit binary, 256 levels
// R7: Pixel is one 24-bit word of channels
// R8: Image shown ten frames after shutdown falls
// R9: Display window starts after back porches
// R10: Host keeps syncs running during shutdown
`timescale 1ns/1ps
`include "rpc_params.svh"
module rpc_panel #(
  parameter int FIFO_DEPTH = `RPC_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pixel_clock,
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic shutdown,
  input wire logic cfg_cs_n,
  input wire logic cfg_sclk,
  input wire logic cfg_sdi,
  output logic [7:0] pix_red,
  output logic [7:0] pix_green,
  output logic [7:0] pix_blue,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic display_on,
  output logic pixel_overrun,
  output logic [23:0] cfg_word,
  output logic cfg_valid,
  output logic cfg_error
);

  // ---------------- Pixel clock domain ----------------

  logic shut_s1_r; // Shutdown synchroniser, first stage
  logic shut_s2_r; // Shutdown synchroniser, second stage
  logic hs_prev_r; // Hsync one clock ago
  logic vs_prev_r; // Vsync one clock ago
  logic hs_fall; // Hsync falling in this clock
  logic vs_fall; // Vsync falling in this clock
  logic [8:0] hpos_r; // Pixel clocks since hsync fall
  logic [8:0] vpos_r; // Lines since vsync fall
  logic h_act; // Inside horizontal display area
  logic v_act; // Inside vertical display area
  rpc_pkg::rpc_pwr_t pwr_r; // Power state
  logic [3:0] frm_cnt_r; // Vsync falls counted in a transition
  logic disp_px_r; // Display enabled, pixel domain
  rpc_pkg::rpc_rgb_t hold_r; // Last captured pixel, held for the core side
  logic tog_r; // Flips once per captured pixel

  // Shutdown pin crosses into the pixel domain
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      shut_s1_r <= 1'b1;
      shut_s2_r <= 1'b1;
    end else begin
      shut_s1_r <= shutdown;
      shut_s2_r <= shut_s1_r;
    end
  end

  // Sync history for edge detection
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      hs_prev_r <= 1'b1;
      vs_prev_r <= 1'b1;
    end else begin
      hs_prev_r <= hsync_n;
      vs_prev_r <= vsync_n;
    end
  end

  assign hs_fall = hs_prev_r && !hsync_n;
  assign vs_fall = vs_prev_r && !vsync_n;

  // Pixel position, one on the clock after the hsync fall
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      hpos_r <= `RPC_POS_IDLE;
    end else if (hs_fall) begin
      hpos_r <= 9'h001; // see R9
    end else if (hpos_r != `RPC_POS_IDLE) begin
      hpos_r <= hpos_r + 9'h001;
    end
  end

  // Line position, vsync fall wins over a coincident hsync fall
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      vpos_r <= `RPC_POS_IDLE;
    end else if (vs_fall) begin
      vpos_r <= 9'h000; // see R9
    end else if (hs_fall && vpos_r != `RPC_POS_IDLE) begin
      vpos_r <= vpos_r + 9'h001;
    end
  end

  // Display window after the back porches; the hsync fall clock is position zero, never shown
  assign h_act = !hs_fall && (hpos_r >= `RPC_HBP) && (hpos_r < `RPC_HBP + `RPC_HDISP); // see R9
  assign v_act = (vpos_r >= `RPC_VBP) && (vpos_r < `RPC_VBP + `RPC_VDISP); // see R9

  // Power sequencing counted in vsync falls
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      pwr_r <= rpc_pkg::RPC_PWR_OFF;
      frm_cnt_r <= 4'h0;
    end else begin
      case (pwr_r)
        rpc_pkg::RPC_PWR_OFF: begin
          // Wake when shutdown goes low
          frm_cnt_r <= 4'h0;
          if (!shut_s2_r) begin
            pwr_r <= rpc_pkg::RPC_PWR_WAKE;
          end
        end
        rpc_pkg::RPC_PWR_WAKE: begin
          if (shut_s2_r) begin
            // Aborted power-up
            pwr_r <= rpc_pkg::RPC_PWR_OFF;
          end else if (vs_fall) begin
            frm_cnt_r <= frm_cnt_r + 4'h1;
            if (frm_cnt_r + 4'h1 == `RPC_ON_FRAMES) begin
              pwr_r <= rpc_pkg::RPC_PWR_ON; // see R8
            end
          end
        end
        rpc_pkg::RPC_PWR_ON: begin
          // Start power-down count on shutdown rise
          frm_cnt_r <= 4'h0;
          if (shut_s2_r) begin
            pwr_r <= rpc_pkg::RPC_PWR_SLEEP;
          end
        end
        rpc_pkg::RPC_PWR_SLEEP: begin
          if (!shut_s2_r) begin
            // Shutdown withdrawn, restart power-up
            pwr_r <= rpc_pkg::RPC_PWR_WAKE;
            frm_cnt_r <= 4'h0;
          end else if (vs_fall) begin
            frm_cnt_r <= frm_cnt_r + 4'h1;
            if (frm_cnt_r + 4'h1 == `RPC_OFF_EDGES) begin
              pwr_r <= rpc_pkg::RPC_PWR_OFF; // see R2
            end
          end
        end
        default: begin
          pwr_r <= rpc_pkg::RPC_PWR_OFF;
          frm_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // Registered display enable, a clean level for the crossing
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      disp_px_r <= 1'b0;
    end else begin
      disp_px_r <= (pwr_r == rpc_pkg::RPC_PWR_ON) || (pwr_r == rpc_pkg::RPC_PWR_SLEEP);
    end
  end

  // Capture each displayed pixel; blanked pixels become black
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      hold_r <= '0;
      tog_r <= 1'b0;
    end else if (h_act && v_act) begin
      hold_r.red <= disp_px_r ? red_in : 8'h00; // see R6
      hold_r.green <= disp_px_r ? green_in : 8'h00; // see R6
      hold_r.blue <= disp_px_r ? blue_in : 8'h00; // see R7
      tog_r <= !tog_r;
    end
  end

  // ---------------- Core clock domain ----------------

  logic disp_s1_r; // Display enable synchroniser, first stage
  logic disp_s2_r; // Display enable synchroniser, second stage
  logic tog_s1_r; // Pixel toggle synchroniser, first stage
  logic tog_s2_r; // Pixel toggle synchroniser, second stage
  logic tog_s3_r; // Pixel toggle history
  logic arrive; // New pixel held by the pixel domain
  logic pend_valid_r; // Pixel waiting for the FIFO
  rpc_pkg::rpc_rgb_t pend_word_r; // Waiting pixel
  logic overrun_r; // Pixel lost to back-pressure
  logic [2:0] cs_sync_r; // Chip select stages, last one is history
  logic [2:0] sck_sync_r; // Serial clock stages, last one is history
  logic [1:0] sdi_sync_r; // Serial data stages
  logic [23:0] shift_r; // Serial shift register
  logic [4:0] bit_cnt_r; // Serial bits in this access
  logic [23:0] cfg_word_r; // Last complete access
  logic cfg_valid_r; // Complete access pulse
  logic cfg_error_r; // Malformed access pulse
  logic sck_rise;
  logic cs_rise;

  rpc_stream_if #(.WIDTH(`RPC_FIFO_WIDTH)) in_if ();
  rpc_stream_if #(.WIDTH(`RPC_FIFO_WIDTH)) out_if ();

  // Level and toggle crossings from the pixel domain
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      disp_s1_r <= 1'b0;
      disp_s2_r <= 1'b0;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      disp_s1_r <= disp_px_r;
      disp_s2_r <= disp_s1_r;
      tog_s1_r <= tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  assign arrive = tog_s2_r ^ tog_s3_r;

  // Holding stage; the held word is stable long after the toggle lands
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_valid_r <= 1'b0;
      pend_word_r <= '0;
    end else if (arrive && (!pend_valid_r || in_if.ready)) begin
      pend_valid_r <= 1'b1;
      pend_word_r <= hold_r; // see R7
    end else if (in_if.ready) begin
      pend_valid_r <= 1'b0;
    end
  end

  // Newest pixel dropped when the FIFO stalls the holding stage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overrun_r <= 1'b0;
    end else begin
      overrun_r <= arrive && pend_valid_r && !in_if.ready;
    end
  end

  assign in_if.valid = pend_valid_r;
  assign in_if.data = pend_word_r;
  assign out_if.ready = pix_ready;

  rpc_fifo #(
    .WIDTH(`RPC_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_s(in_if),
    .out_s(out_if)
  );

  // Serial pins cross into the core domain
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cs_sync_r <= 3'h7;
      sck_sync_r <= 3'h0;
      sdi_sync_r <= 2'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], cfg_cs_n};
      sck_sync_r <= {sck_sync_r[1:0], cfg_sclk};
      sdi_sync_r <= {sdi_sync_r[0], cfg_sdi};
    end
  end

  assign sck_rise = sck_sync_r[1] && !sck_sync_r[2];
  assign cs_rise = cs_sync_r[1] && !cs_sync_r[2];

  // Shift in MSB first on serial clock rise while selected
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= 24'h000000;
      bit_cnt_r <= 5'h00;
    end else if (cs_sync_r[1]) begin
      bit_cnt_r <= 5'h00;
    end else if (sck_rise) begin
      shift_r <= {shift_r[22:0], sdi_sync_r[1]};
      if (bit_cnt_r != `RPC_CFG_SAT) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // Deselect closes the access; only exactly 24 bits is accepted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_word_r <= 24'h000000;
      cfg_valid_r <= 1'b0;
      cfg_error_r <= 1'b0;
    end else begin
      cfg_valid_r <= cs_rise && (bit_cnt_r == `RPC_CFG_BITS); // see R5
      cfg_error_r <= cs_rise && (bit_cnt_r != `RPC_CFG_BITS); // see R5
      if (cs_rise && bit_cnt_r == `RPC_CFG_BITS) begin
        cfg_word_r <= shift_r;
      end
    end
  end

  // Outputs
  assign pix_red = out_if.data[7:0];
  assign pix_green = out_if.data[15:8];
  assign pix_blue = out_if.data[23:16];
  assign pix_valid = out_if.valid;
  assign display_on = disp_s2_r;
  assign pixel_overrun = overrun_r;
  assign cfg_word = cfg_word_r;
  assign cfg_valid = cfg_valid_r;
  assign cfg_error = cfg_error_r;

endmodule

// ==== src/rpc_params.svh ====
// Constants for the RGB panel pixel front end: porches, sequence counts, serial framing
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// Horizontal timing in pixel clocks, counted from the hsync falling edge
`define RPC_HBP 9'd8
`define RPC_HDISP 9'd320
// Vertical timing in lines, counted from the vsync falling edge
`define RPC_VBP 9'd2
`define RPC_VDISP 9'd240
// Saturation value of the line and pixel position counters
`define RPC_POS_IDLE 9'h1ff
// Vsync falling edges from shutdown rise to blanking
`define RPC_OFF_EDGES 4'd2
// Frames from shutdown fall to image shown
`define RPC_ON_FRAMES 4'd10
// Bits in one serial configuration access
`define RPC_CFG_BITS 5'd24
// Saturation value of the serial bit counter
`define RPC_CFG_SAT 5'h1f
// Default FIFO shape
`define RPC_FIFO_WIDTH 24
`define RPC_FIFO_DEPTH 8

`endif

// ==== src/rpc_pkg.sv ====
// Types shared by the RGB panel pixel front end
package rpc_pkg;

  // One pixel word, red in the low byte, bit 0 is red_bit_lsb
  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } rpc_rgb_t;

  // Panel power states, kept in the pixel clock domain
  typedef enum logic [1:0] {
    RPC_PWR_OFF,
    RPC_PWR_WAKE,
    RPC_PWR_ON,
    RPC_PWR_SLEEP
  } rpc_pwr_t;

endpackage

// ==== src/rpc_stream_if.sv ====
// Valid/ready word stream between the panel front end and its FIFO
`timescale 1ns/1ps
interface rpc_stream_if #(
  parameter int WIDTH = 24
) ();
  logic [WIDTH-1:0] data; // Word carried
  logic valid; // Word offered
  logic ready; // Word can be taken

  // Producer side
  modport src (output data, output valid, input ready);
  // Consumer side
  modport snk (input data, input valid, output ready);
endinterface

// ==== src/rpc_fifo.sv ====
// Single clock FIFO with flip-flop storage and valid/ready on both sides
`timescale 1ns/1ps
`include "rpc_params.svh"
module rpc_fifo #(
  parameter int WIDTH = `RPC_FIFO_WIDTH,
  parameter int DEPTH = `RPC_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  rpc_stream_if.snk in_s,
  rpc_stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse shapes the pointer arithmetic cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1 || $bits(in_s.data) != WIDTH) begin : g_bad
    $error("rpc_fifo needs a power of two depth and matching width");
  end

  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage words
  logic [AW:0] wr_ptr_r; // Write index with wrap bit
  logic [AW:0] rd_ptr_r; // Read index with wrap bit
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Full when indices match and wrap bits differ
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign push = in_s.valid && !full;
  assign pop = out_s.valid && out_s.ready;
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_r[rd_ptr_r[AW-1:0]];

  // Storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_s.data;
    end
  end

  // Write pointer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// ==== verification/rpc_panel_chk.sv ====
// Port-level checker for the panel front end
`timescale 1ns/1ps
module rpc_panel_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic shutdown,
  input wire logic cfg_cs_n,
  input wire logic [7:0] pix_red,
  input wire logic [7:0] pix_green,
  input wire logic [7:0] pix_blue,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic display_on,
  input wire logic pixel_overrun,
  input wire logic [23:0] cfg_word,
  input wire logic cfg_valid,
  input wire logic cfg_error
);
  // All checks live in the core domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Closing a serial access is answered within a few cycles
  a_cfg_answer: assert property ($rose(cfg_cs_n) |-> ##[2:6] (cfg_valid || cfg_error))
    else $error("serial access not answered");
  // An answer only comes once select is released
  a_cfg_after_close: assert property ((cfg_valid || cfg_error) |-> $past(cfg_cs_n, 2))
    else $error("serial answer while selected");
  // Captured word moves only with its valid pulse
  a_cfg_word_hold: assert property ($changed(cfg_word) |-> cfg_valid)
    else $error("config word changed without valid");
  // A refused access leaves the word alone and is a single pulse
  a_cfg_error_keep: assert property (cfg_error |-> $stable(cfg_word) ##1 !cfg_error)
    else $error("config error altered word");
  // Image appears only with shutdown low
  a_on_needs_wake: assert property ($rose(display_on) |-> !shutdown)
    else $error("display on while shut");
  // Blanking only follows a shutdown request
  a_off_needs_shut: assert property ($fell(display_on) |-> shutdown)
    else $error("display off without shutdown");
  // Offered pixel word holds until taken
  a_pix_hold: assert property (pix_valid && !pix_ready |=>
    pix_valid && $stable({pix_blue, pix_green, pix_red}))
    else $error("pixel word changed before taken");
  // Dropped pixel is a one-cycle pulse with storage occupied
  a_overrun_pulse: assert property (pixel_overrun |-> pix_valid ##1 !pixel_overrun)
    else $error("overrun pulse malformed");
endmodule

// ==== verification/rpc_host_model.sv ====
// Host display controller model: free pixel clock, short frames, colour source
`timescale 1ns/1ps
module rpc_host_model #(
  parameter int LINE_CLKS = 28,
  parameter int FRAME_LINES = 5
) (
  output logic pixel_clock,
  output logic hsync_n,
  output logic vsync_n,
  output logic [7:0] red_in,
  output logic [7:0] green_in,
  output logic [7:0] blue_in,
  input wire logic use_pos,
  input wire logic [23:0] color_word
);
  int h; // Clock within line
  int v; // Line within frame

  // Pixel clock never stops, also through shutdown frames
  initial begin
    h = 0;
    v = 0;
    hsync_n = 1'b1;
    vsync_n = 1'b1;
    red_in = 8'h00;
    green_in = 8'h00;
    blue_in = 8'h00;
    pixel_clock = 1'b0;
    #7;
    forever #24 pixel_clock = ~pixel_clock;
  end

  // Syncs keep running; data moves on the falling edge, clear of capture
  always @(negedge pixel_clock) begin
    h = (h == LINE_CLKS - 1) ? 0 : h + 1;
    if (h == 0) begin
      v = (v == FRAME_LINES - 1) ? 0 : v + 1;
    end
    hsync_n <= (h != 0);
    vsync_n <= !(v == 0 && h < 4);
    // Position pattern puts clock in red and line in green
    red_in <= use_pos ? 8'(h) : color_word[7:0];
    green_in <= use_pos ? 8'(v) : color_word[15:8];
    blue_in <= color_word[23:16];
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the panel front end
`timescale 1ns/1ps
`include "rpc_params.svh"
module tb_top;
  localparam int LINE_CLKS = 28; // Short lines keep the run brief
  localparam int FRAME_LINES = 5; // Short frames keep the run brief
  localparam int WIN_PIX = (FRAME_LINES - 2) * (LINE_CLKS - 8); // Shown pixels per frame
  logic core_clk, resetn, shutdown, cfg_cs_n, cfg_sclk, cfg_sdi, pix_ready, use_pos;
  logic pixel_clock, hsync_n, vsync_n, pix_valid, display_on, pixel_overrun;
  logic cfg_valid, cfg_error, ovr_seen;
  logic [7:0] red_in, green_in, blue_in, pix_red, pix_green, pix_blue;
  logic [23:0] color_word, cfg_word;
  logic [23:0] q[$]; // Words taken from the device
  int n_mismatch = 0;
  int n_checks = 0;

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  rpc_host_model #(.LINE_CLKS(LINE_CLKS), .FRAME_LINES(FRAME_LINES)) i_host (
    .pixel_clock(pixel_clock), .hsync_n(hsync_n), .vsync_n(vsync_n), .red_in(red_in),
    .green_in(green_in), .blue_in(blue_in), .use_pos(use_pos), .color_word(color_word));

  rpc_panel i_dut (
    .core_clk(core_clk), .resetn(resetn), .pixel_clock(pixel_clock), .hsync_n(hsync_n),
    .vsync_n(vsync_n), .red_in(red_in), .green_in(green_in), .blue_in(blue_in),
    .shutdown(shutdown), .cfg_cs_n(cfg_cs_n), .cfg_sclk(cfg_sclk), .cfg_sdi(cfg_sdi),
    .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .display_on(display_on), .pixel_overrun(pixel_overrun),
    .cfg_word(cfg_word), .cfg_valid(cfg_valid), .cfg_error(cfg_error));

  // Collect each word handed out and note dropped pixels
  always @(posedge core_clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      q.push_back({pix_blue, pix_green, pix_red});
    end
    if (pixel_overrun === 1'b1) begin
      ovr_seen = 1'b1;
    end
  end

  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Report counts and verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Let a number of core cycles pass, landing off the edge
  task automatic core(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Wait for n falling edges of vertical sync, bounded
  task automatic vfalls(input int n);
    int k;
    logic last;
    k = 0;
    last = vsync_n;
    while (n > 0 && k < 2000) begin
      @(posedge pixel_clock);
      k++;
      if (last && !vsync_n) begin
        n--;
      end
      last = vsync_n;
    end
    if (n > 0) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Serial write of the top n bits of v, first bit on the wire is bit 23
  task automatic send(input logic [23:0] v, input int n);
    @(posedge core_clk) cfg_cs_n <= 1'b0;
    for (int i = 23; i >= 24 - n; i--) begin
      @(posedge core_clk) cfg_sdi <= v[i];
      repeat (6) @(posedge core_clk);
      cfg_sclk <= 1'b1;
      repeat (6) @(posedge core_clk);
      cfg_sclk <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    cfg_cs_n <= 1'b1;
  endtask

  // Wait for the accept or refuse pulse, bounded
  task automatic answer(input logic good);
    int k;
    k = 0;
    while (k < 20 && (good ? cfg_valid : cfg_error) !== 1'b1) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 20) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // While off, captured pixels come out black, one word per window pixel
  task automatic t_dark;
    vfalls(1);
    q.delete();
    vfalls(1);
    core(20);
    check(24'(q.size()), 24'(WIN_PIX));
    check(q[0], 24'h000000);
  endtask

  // Image shows on the tenth frame after shutdown falls, not before
  task automatic t_wake;
    @(posedge core_clk) shutdown <= 1'b0;
    vfalls(9);
    core(20);
    check(24'(display_on), 24'h0);
    vfalls(1);
    core(20);
    check(24'(display_on), 24'h1);
  endtask

  // First shown pixel sits past both back porches; channels pack blue, green, red
  task automatic t_window;
    vfalls(1);
    q.delete();
    vfalls(1);
    core(20);
    check(24'(q.size()), 24'(WIN_PIX));
    check(q[0], 24'hff0208);
    check(q[WIN_PIX - 1], {8'hff, 8'(FRAME_LINES - 1), 8'(LINE_CLKS - 1)});
  endtask

  // Basic colours and gray level extremes pass through unchanged
  task automatic t_colours;
    logic [23:0] tbl[10] = '{24'h000000, 24'hff0000, 24'h00ff00, 24'hffff00, 24'h0000ff,
      24'hff00ff, 24'h00ffff, 24'hffffff, 24'h000001, 24'h00fe00};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk) use_pos <= 1'b0;
      color_word <= tbl[i];
      vfalls(2);
      core(20);
      check(q[$], tbl[i]);
    end
  endtask

  // Stall the consumer a whole frame: storage fills, overflow drops, then drains
  task automatic t_overrun;
    vfalls(1);
    @(posedge core_clk) pix_ready <= 1'b0;
    ovr_seen = 1'b0;
    vfalls(1);
    q.delete();
    @(posedge core_clk) pix_ready <= 1'b1;
    core(30);
    check(24'(ovr_seen), 24'h1);
    check(24'(q.size()), 24'(`RPC_FIFO_DEPTH + 1));
  endtask

  // Full access is taken; a short one is refused and keeps the old word
  task automatic t_cfg;
    send(24'ha5c3e1, 24);
    answer(1'b1);
    check(cfg_word, 24'ha5c3e1);
    send(24'h123456, 23);
    answer(1'b0);
    check(cfg_word, 24'ha5c3e1);
  endtask

  // Blanking lands on the second vertical sync fall after shutdown rises
  task automatic t_sleep;
    vfalls(1);
    @(posedge core_clk) shutdown <= 1'b1;
    vfalls(1);
    core(20);
    check(24'(display_on), 24'h1);
    vfalls(1); // Two frames pass before the display counts as off
    core(20);
    check(24'(display_on), 24'h0);
  endtask

  // Reset only at the start, with shutdown held high
  initial begin
    resetn = 1'b0;
    shutdown = 1'b1;
    cfg_cs_n = 1'b1;
    cfg_sclk = 1'b0;
    cfg_sdi = 1'b0;
    pix_ready = 1'b1;
    use_pos = 1'b1;
    color_word = 24'hffffff;
    ovr_seen = 1'b0;
    repeat (4) @(posedge pixel_clock);
    @(posedge core_clk) resetn <= 1'b1;
    t_dark();
    t_wake();
    t_window();
    t_cfg();
    t_overrun();
    t_colours();
    t_sleep();
    tally_and_finish();
  end
endmodule

bind rpc_panel rpc_panel_chk i_chk (
  .core_clk(core_clk), .resetn(resetn), .shutdown(shutdown), .cfg_cs_n(cfg_cs_n),
  .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .display_on(display_on), .pixel_overrun(pixel_overrun),
  .cfg_word(cfg_word), .cfg_valid(cfg_valid), .cfg_error(cfg_error));
